// >>> hw/tlos_regs.svh
// Register offsets, field positions, reset values and timing counts
// Assumes a 32-bit APB slave with word-aligned registers
//
// What this block does
// - Analog line outputs used only when digital select clear
// - Analog outputs tristate until coding bit1, tristate clear
// - Digital select and coding bit1 give dual rail
// - Full-baud bit picks 50% or 100% pulses
// - Dual-rail outputs change on line clock rise
// - Polarity bit sets dual rail; reset active low
// - Digital outputs tristate until select set, tristate clear
// - Select set, coding bit1 clear give optical mode
// - Optical unipolar data timed on line clock rise
// - NRZ optical bit held whole bit period
// - CMI optical output changes on both clock edges
// - Polarity bit sets optical data; reset active high
// - Frame marker pulses on first bit of frame
// - Frame marker only in optical mode
`ifndef TLOS_REGS_SVH
`define TLOS_REGS_SVH

// ----------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------
`define TLOS_CTRL_OFFSET     12'h000
`define TLOS_STATUS_OFFSET   12'h004

// ----------------------------------------------------------------
// Control fields
// ----------------------------------------------------------------
`define TLOS_CTRL_WIDTH      6
`define TLOS_CTRL_DIGSEL     0
`define TLOS_CTRL_CODE1      1
`define TLOS_CTRL_TRIST      2
`define TLOS_CTRL_FULLB      3
`define TLOS_CTRL_POL        4
`define TLOS_CTRL_CMI        5
`define TLOS_CTRL_RESET      6'h00

// ----------------------------------------------------------------
// Status fields
// ----------------------------------------------------------------
`define TLOS_STAT_CLK        0
`define TLOS_STAT_MODE_LSB   1
`define TLOS_STAT_OE_LSB     3

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define TLOS_SYNC_STAGES     2

`endif

// >>> hw/tlos_pkg.sv
// Types shared by the transmit line output select block
// Assumes the constants header is included by each module
package tlos_pkg;

   typedef enum logic [1:0] {
      TLOS_MODE_ANALOG,
      TLOS_MODE_DUAL,
      TLOS_MODE_OPTICAL
   } tlos_mode_t;

endpackage

// >>> hw/tlos_edge_if.sv
// Edge events of the synchronised line clock
// Assumes both ends run on pclk
`timescale 1ns/1ps

interface tlos_edge_if;
   logic rise;
   logic fall;
   logic level;

   modport src (output rise, output fall, output level);
   modport dst (input rise, input fall, input level);
endinterface

// >>> hw/tlos_edge_detect.sv
// Synchroniser and edge finder for the line clock
// Assumes the line clock is far slower than pclk
`timescale 1ns/1ps
`include "tlos_regs.svh"

module tlos_edge_detect #(
   parameter int STAGES = `TLOS_SYNC_STAGES
) (
   input  wire logic  pclk,
   input  wire logic  presetn,
   input  wire logic  clk_in,
   tlos_edge_if.src   edges
);

   logic [STAGES-1:0] sync;
   logic [STAGES-1:0] next_sync;
   logic              prev;
   logic              next_prev;

   initial begin
      if (STAGES < 2) begin
         $error("tlos_edge_detect needs at least two stages");
      end
   end

   // ----------------------------------------------------------------
   // Sync chain
   // ----------------------------------------------------------------
   always_comb begin
      next_sync = {sync[STAGES-2:0], clk_in};
      next_prev = sync[STAGES-1];
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         sync <= '0;
         prev <= 1'b0;
      end else begin
         sync <= next_sync;
         prev <= next_prev;
      end
   end

   // ----------------------------------------------------------------
   // Edge events
   // ----------------------------------------------------------------
   assign edges.rise  = sync[STAGES-1] & ~prev;
   assign edges.fall  = ~sync[STAGES-1] & prev;
   assign edges.level = sync[STAGES-1];

endmodule

// >>> hw/tlos_tx_line_select.sv
// Transmit line output select: analog, dual-rail or optical output
// Assumes framer inputs on pclk and an APB master on pclk
//
// The register offsets and the APB slave port are this design's own decisions.
`timescale 1ns/1ps
`include "tlos_regs.svh"

module tlos_tx_line_select
   import tlos_pkg::*;
#(
   parameter int ADDR_W      = 12,
   parameter int SYNC_STAGES = `TLOS_SYNC_STAGES
) (
   input  wire logic              pclk,
   input  wire logic              presetn,
   input  wire logic              psel,
   input  wire logic              penable,
   input  wire logic              pwrite,
   input  wire logic [ADDR_W-1:0] paddr,
   input  wire logic [31:0]       pwdata,
   output logic [31:0]            prdata,
   output logic                   pready,
   output logic                   pslverr,
   input  wire logic              tx_line_clock,
   input  wire logic              tx_bit_in,
   input  wire logic              tx_mark_pos_in,
   input  wire logic              tx_mark_neg_in,
   input  wire logic              tx_frame_first_in,
   output logic                   analog_tx_line_a,
   output logic                   analog_tx_line_a_oe,
   output logic                   analog_tx_line_b,
   output logic                   analog_tx_line_b_oe,
   output logic                   tx_pulse_out_pos,
   output logic                   tx_pulse_out_pos_oe,
   output logic                   tx_pulse_out_neg,
   output logic                   tx_pulse_out_neg_oe,
   output logic                   optical_tx_data_out,
   output logic                   optical_tx_data_out_oe,
   output logic                   tx_frame_marker,
   output logic                   tx_frame_marker_oe
);

   initial begin
      if (ADDR_W < 3 || ADDR_W > 32) begin
         $error("tlos_tx_line_select address width out of range");
      end
   end

   // ----------------------------------------------------------------
   // Line clock edges
   // ----------------------------------------------------------------
   tlos_edge_if lclk_if();

   tlos_edge_detect #(
      .STAGES (SYNC_STAGES)
   ) u_edge (
      .pclk    (pclk),
      .presetn (presetn),
      .clk_in  (tx_line_clock),
      .edges   (lclk_if)
   );

   // ----------------------------------------------------------------
   // Control register and APB slave
   // ----------------------------------------------------------------
   logic [`TLOS_CTRL_WIDTH-1:0] ctrl;
   logic [`TLOS_CTRL_WIDTH-1:0] next_ctrl;
   logic [31:0]                 next_prdata;
   logic                        next_pready;
   logic                        next_pslverr;
   logic [31:0]                 status_word;
   logic                        hit_ctrl;
   logic                        hit_status;
   logic                        access;

   logic digsel;
   logic code1;
   logic trist;
   logic fullb;
   logic pol;
   logic cmi;

   assign digsel = ctrl[`TLOS_CTRL_DIGSEL];
   assign code1  = ctrl[`TLOS_CTRL_CODE1];
   assign trist  = ctrl[`TLOS_CTRL_TRIST];
   assign fullb  = ctrl[`TLOS_CTRL_FULLB];
   assign pol    = ctrl[`TLOS_CTRL_POL];
   assign cmi    = ctrl[`TLOS_CTRL_CMI];

   assign hit_ctrl   = paddr == ADDR_W'(`TLOS_CTRL_OFFSET);
   assign hit_status = paddr == ADDR_W'(`TLOS_STATUS_OFFSET);
   assign access     = psel & penable & ~pready;

   always_comb begin
      next_ctrl    = ctrl;
      next_prdata  = 32'h00000000;
      next_pready  = access;
      next_pslverr = 1'b0;
      if (access) begin
         if (hit_ctrl) begin
            next_prdata = {{(32-`TLOS_CTRL_WIDTH){1'b0}}, ctrl};
            if (pwrite) begin
               next_ctrl = pwdata[`TLOS_CTRL_WIDTH-1:0];
            end
         end else if (hit_status) begin
            if (!pwrite) begin
               next_prdata = status_word;
            end
         end else begin
            next_pslverr = 1'b1;
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ctrl    <= `TLOS_CTRL_RESET;
         prdata  <= 32'h00000000;
         pready  <= 1'b0;
         pslverr <= 1'b0;
      end else begin
         ctrl    <= next_ctrl;
         prdata  <= next_prdata;
         pready  <= next_pready;
         pslverr <= next_pslverr;
      end
   end

   // ----------------------------------------------------------------
   // Mode decode
   // ----------------------------------------------------------------
   tlos_mode_t mode;

   always_comb begin
      if (!digsel) begin
         mode = TLOS_MODE_ANALOG;
      end else if (code1) begin
         mode = TLOS_MODE_DUAL;
      end else begin
         mode = TLOS_MODE_OPTICAL;
      end
   end

   // ----------------------------------------------------------------
   // Symbol state on line clock edges
   // ----------------------------------------------------------------
   logic pos_act;
   logic neg_act;
   logic opt_act;
   logic fm_act;
   logic cmi_alt;
   logic cmi_zero;
   logic next_pos_act;
   logic next_neg_act;
   logic next_opt_act;
   logic next_fm_act;
   logic next_cmi_alt;
   logic next_cmi_zero;

   always_comb begin
      next_pos_act  = pos_act;
      next_neg_act  = neg_act;
      next_opt_act  = opt_act;
      next_fm_act   = fm_act;
      next_cmi_alt  = cmi_alt;
      next_cmi_zero = cmi_zero;
      if (lclk_if.rise) begin
         next_pos_act  = tx_mark_pos_in;
         next_neg_act  = tx_mark_neg_in;
         next_cmi_zero = ~tx_bit_in;
         if (cmi) begin
            if (tx_bit_in) begin
               next_opt_act = ~cmi_alt;
               next_cmi_alt = ~cmi_alt;
            end else begin
               next_opt_act = 1'b0;
            end
         end else begin
            next_opt_act = tx_bit_in;
         end
         next_fm_act = tx_frame_first_in & (mode == TLOS_MODE_OPTICAL);
      end else if (lclk_if.fall) begin
         if (!fullb) begin
            next_pos_act = 1'b0;
            next_neg_act = 1'b0;
         end
         if (cmi && cmi_zero) begin
            next_opt_act = 1'b1;
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pos_act  <= 1'b0;
         neg_act  <= 1'b0;
         opt_act  <= 1'b0;
         fm_act   <= 1'b0;
         cmi_alt  <= 1'b0;
         cmi_zero <= 1'b0;
      end else begin
         pos_act  <= next_pos_act;
         neg_act  <= next_neg_act;
         opt_act  <= next_opt_act;
         fm_act   <= next_fm_act;
         cmi_alt  <= next_cmi_alt;
         cmi_zero <= next_cmi_zero;
      end
   end

   // ----------------------------------------------------------------
   // Pin levels and enables
   // ----------------------------------------------------------------
   logic next_line_a;
   logic next_line_b;
   logic next_line_oe;
   logic next_pos_pin;
   logic next_neg_pin;
   logic next_opt_pin;
   logic next_fm_pin;
   logic next_dual_oe;
   logic next_opt_oe;

   always_comb begin
      next_line_a  = pos_act;
      next_line_b  = neg_act;
      next_line_oe = (mode == TLOS_MODE_ANALOG) & code1 & ~trist;
      next_pos_pin = pol ? pos_act : ~pos_act;
      next_neg_pin = pol ? neg_act : ~neg_act;
      next_opt_pin = pol ? ~opt_act : opt_act;
      next_fm_pin  = fm_act;
      next_dual_oe = (mode == TLOS_MODE_DUAL) & ~trist;
      next_opt_oe  = (mode == TLOS_MODE_OPTICAL) & ~trist;
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         analog_tx_line_a       <= 1'b0;
         analog_tx_line_a_oe    <= 1'b0;
         analog_tx_line_b       <= 1'b0;
         analog_tx_line_b_oe    <= 1'b0;
         tx_pulse_out_pos       <= 1'b1;
         tx_pulse_out_pos_oe    <= 1'b0;
         tx_pulse_out_neg       <= 1'b1;
         tx_pulse_out_neg_oe    <= 1'b0;
         optical_tx_data_out    <= 1'b0;
         optical_tx_data_out_oe <= 1'b0;
         tx_frame_marker        <= 1'b0;
         tx_frame_marker_oe     <= 1'b0;
      end else begin
         analog_tx_line_a       <= next_line_a;
         analog_tx_line_a_oe    <= next_line_oe;
         analog_tx_line_b       <= next_line_b;
         analog_tx_line_b_oe    <= next_line_oe;
         tx_pulse_out_pos       <= next_pos_pin;
         tx_pulse_out_pos_oe    <= next_dual_oe;
         tx_pulse_out_neg       <= next_neg_pin;
         tx_pulse_out_neg_oe    <= next_dual_oe;
         optical_tx_data_out    <= next_opt_pin;
         optical_tx_data_out_oe <= next_opt_oe;
         tx_frame_marker        <= next_fm_pin;
         tx_frame_marker_oe     <= next_opt_oe;
      end
   end

   // ----------------------------------------------------------------
   // Status word
   // ----------------------------------------------------------------
   always_comb begin
      status_word = 32'h00000000;
      status_word[`TLOS_STAT_CLK] = lclk_if.level;
      status_word[`TLOS_STAT_MODE_LSB +: 2] = mode;
      status_word[`TLOS_STAT_OE_LSB]     = analog_tx_line_a_oe;
      status_word[`TLOS_STAT_OE_LSB + 1] = tx_pulse_out_pos_oe;
      status_word[`TLOS_STAT_OE_LSB + 2] = optical_tx_data_out_oe;
   end

endmodule

// >>> verif/tlos_checker.sv
// Checker: output enables, frame marker and APB answer of the line select
// Assumes binding to tlos_tx_line_select, single pclk domain
`timescale 1ns/1ps

module tlos_checker (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pready,
   input wire logic pslverr,
   input wire logic tx_frame_first_in,
   input wire logic analog_tx_line_a_oe,
   input wire logic analog_tx_line_b_oe,
   input wire logic tx_pulse_out_pos_oe,
   input wire logic tx_pulse_out_neg_oe,
   input wire logic optical_tx_data_out_oe,
   input wire logic tx_frame_marker,
   input wire logic tx_frame_marker_oe
);
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   ana_excl_a: assert property (analog_tx_line_a_oe |-> !tx_pulse_out_pos_oe)
      else $error("analog and dual both driven");
   ana_pair_a: assert property (analog_tx_line_a_oe == analog_tx_line_b_oe)
      else $error("analog enables differ");
   dual_pair_a: assert property (tx_pulse_out_pos_oe == tx_pulse_out_neg_oe)
      else $error("dual enables differ");
   opt_excl_a: assert property (optical_tx_data_out_oe |-> !tx_pulse_out_pos_oe)
      else $error("optical and dual both driven");
   mark_mode_a: assert property (tx_frame_marker_oe == optical_tx_data_out_oe)
      else $error("marker enable outside optical mode");
   oe_hold_a: assert property (!psel && !$past(psel) && !$past(psel, 2) |->
      $stable({analog_tx_line_a_oe, tx_pulse_out_pos_oe, optical_tx_data_out_oe}))
      else $error("enable moved without a write");
   mark_cause_a: assert property ($rose(tx_frame_marker) && tx_frame_marker_oe |->
      $past(tx_frame_first_in)) else $error("marker without first bit");
   mark_len_a: assert property ($rose(tx_frame_marker) && tx_frame_marker_oe |=>
      tx_frame_marker [*7]) else $error("marker shorter than a bit");
   apb_wait_a: assert property (psel && penable && !pready |=> pready)
      else $error("no answer after one wait state");
   apb_pulse_a: assert property (pready |=> !pready) else $error("pready held");
   err_with_a: assert property (pslverr |-> pready) else $error("pslverr without pready");

   cover property (analog_tx_line_a_oe);
   cover property (tx_pulse_out_pos_oe);
   cover property ($rose(tx_frame_marker) && tx_frame_marker_oe);
endmodule

bind tlos_tx_line_select tlos_checker i_tlos_checker (.pclk, .presetn, .psel, .penable,
   .pready, .pslverr, .tx_frame_first_in, .analog_tx_line_a_oe, .analog_tx_line_b_oe,
   .tx_pulse_out_pos_oe, .tx_pulse_out_neg_oe, .optical_tx_data_out_oe, .tx_frame_marker,
   .tx_frame_marker_oe);

// >>> verif/tlos_line_model.sv
// Far side model: resolves the digital transmit wires, counts frame marks
// Assumes pin order {pos, neg, optical, marker} with enables alike
`timescale 1ns/1ps

module tlos_line_model (
   input wire logic       pclk,
   input wire logic [3:0] pin,
   input wire logic [3:0] oe,
   input wire logic       remote_loop,
   output logic [3:0]     wire_lvl,
   output logic [7:0]     mark_cnt
);
   logic [3:0] last = 4'h0;
   logic [7:0] cnt  = 8'h00;

   assign mark_cnt = cnt;
   // Released wire shows inverse of last level
   always_comb begin
      for (int i = 0; i < 4; i++) wire_lvl[i] = oe[i] ? pin[i] : ~last[i];
   end
   always @(posedge pclk) begin
      for (int i = 0; i < 4; i++) if (oe[i]) last[i] <= pin[i];
      if (oe[0] && pin[0] && !last[0] && !remote_loop) cnt <= cnt + 8'h01;
   end
endmodule

// >>> verif/tb_transmit_line_output_select.sv
// Testbench: APB mode setup, transmit streams judged at the far side model
// Assumes the line select top, its checker bind and the line model
`timescale 1ns/1ps
`include "tlos_regs.svh"

module tb_transmit_line_output_select;
   logic        pclk = 1'b0, presetn = 1'b0, tx_line_clock = 1'b0;
   logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0, pready, pslverr, rerr, a_oe, b_oe;
   logic        la, lb, rloop = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h00000000, prdata, rdat;
   logic [3:0]  fin = 4'h0, pins, oes, wl;
   logic [7:0]  mark_cnt;
   logic [5:0]  mc [6] = '{6'h02, 6'h06, 6'h03, 6'h01, 6'h05, 6'h00};
   logic [2:0]  me [6] = '{3'h1, 3'h0, 3'h2, 3'h4, 3'h0, 3'h0};
   int          n_fail = 0, total_checks = 0, cyc = 0;

   tlos_tx_line_select i_tlos_tx_line_select (.pclk, .presetn, .psel, .penable, .pwrite,
      .paddr, .pwdata, .prdata, .pready, .pslverr, .tx_line_clock, .tx_bit_in(fin[1]),
      .tx_mark_pos_in(fin[3]), .tx_mark_neg_in(fin[2]), .tx_frame_first_in(fin[0]),
      .analog_tx_line_a(la), .analog_tx_line_a_oe(a_oe), .analog_tx_line_b(lb),
      .analog_tx_line_b_oe(b_oe), .tx_pulse_out_pos(pins[3]), .tx_pulse_out_pos_oe(oes[3]),
      .tx_pulse_out_neg(pins[2]), .tx_pulse_out_neg_oe(oes[2]),
      .optical_tx_data_out(pins[1]), .optical_tx_data_out_oe(oes[1]),
      .tx_frame_marker(pins[0]), .tx_frame_marker_oe(oes[0]));
   tlos_line_model i_tlos_line_model (.pclk, .pin(pins), .oe(oes), .remote_loop(rloop),
      .wire_lvl(wl), .mark_cnt);

   always #50 pclk = ~pclk;
   initial begin
      #137;
      forever #400 tx_line_clock = ~tx_line_clock;
   end

   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      total_checks++;
      if (seen !== exp) begin
         n_fail++;
         $display("wrong value %s expected %h seen %h", what, exp, seen);
      end
   endtask

   task automatic end_of_test();
      $display("checks %0d mismatches %0d", total_checks, n_fail);
      if (n_fail == 0 && total_checks > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask

   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      int n = 0;
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 50);
      rdat = prdata;
      rerr = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      if (n == 50) n_fail++;
   endtask

   // Three line bits: in {pos,neg,data,first}, out {pos,neg,opt,mark}
   task automatic run(input string nm, input logic [5:0] c, input logic [11:0] s,
                      input logic [11:0] e1, input logic [11:0] e2, input logic [3:0] m);
      apb(1'b1, `TLOS_CTRL_OFFSET, {26'h0, c});
      for (int i = 2; i >= 0; i--) begin
         @(posedge tx_line_clock);
         @(posedge pclk);
         fin <= s[i*4+:4];
         repeat (3) @(posedge pclk);
         @(negedge pclk);
         check({nm, " first half"}, 32'(wl & m), 32'(e1[i*4+:4] & m));
         @(negedge tx_line_clock);
         repeat (4) @(posedge pclk);
         @(negedge pclk);
         check({nm, " second half"}, 32'(wl & m), 32'(e2[i*4+:4] & m));
      end
      @(posedge pclk);
      fin <= 4'h0;
      $display("test %s done", nm);
   endtask

   always @(posedge pclk) begin
      cyc++;
      if (cyc == 5000) begin
         n_fail++;
         end_of_test();
      end
   end

   initial begin
      repeat (10) @(posedge pclk);
      presetn <= 1'b1;
      @(negedge pclk);
      check("reset pins", 32'({pins[3:2], oes, a_oe, b_oe}), 32'h000000C0);
      apb(1'b0, `TLOS_CTRL_OFFSET, 32'h0);
      check("ctrl reset", rdat, 32'h0);
      apb(1'b0, 12'h008, 32'h0);
      check("unmapped error", 32'(rerr), 32'h00000001);
      check("unmapped data", rdat, 32'h00000000);
      $display("test reset done");
      for (int i = 0; i < 6; i++) begin
         apb(1'b1, `TLOS_CTRL_OFFSET, {26'h0, mc[i]});
         repeat (2) @(posedge pclk);
         check("pin enables", 32'({oes, b_oe, a_oe}),
               32'({{2{me[i][1]}}, {2{me[i][2]}}, {2{me[i][0]}}}));
         apb(1'b0, `TLOS_STATUS_OFFSET, 32'h0);
         check("status", 32'(rdat[5:1]),
               32'({me[i], mc[i][0] ? (mc[i][1] ? 2'd1 : 2'd2) : 2'd0}));
      end
      $display("test modes done");
      run("cmi", 6'h21, 12'h220, 12'h200, 12'h202, 4'h2);
      run("nrz", 6'h01, 12'h302, 12'h302, 12'h302, 4'h3);
      rloop <= 1'b1;
      run("nrz inverted", 6'h11, 12'h302, 12'h120, 12'h120, 4'h3);
      rloop <= 1'b0;
      check("marks", 32'(mark_cnt), 32'h00000001);
      run("half baud", 6'h03, 12'h840, 12'h48C, 12'hCCC, 4'hC);
      run("full baud", 6'h0B, 12'h840, 12'h48C, 12'h48C, 4'hC);
      run("dual inverted", 6'h13, 12'h840, 12'h840, 12'h000, 4'hC);
      apb(1'b1, `TLOS_CTRL_OFFSET, 32'h0000000A);
      @(posedge pclk);
      fin <= 4'h8;
      repeat (12) @(posedge pclk);
      check("analog lines", 32'({a_oe, b_oe, la, lb}), 32'h0000000E);
      @(posedge pclk);
      fin <= 4'h0;
      $display("test analog done");
      end_of_test();
   end
endmodule
